// File: pkg/fss_pkg.sv
package fss_pkg;
  // Application-layer states
  typedef enum logic [2:0] {
    FSS_INIT, FSS_PREOP, FSS_SAFE_OPERATIONAL_MODE, FSS_OP, FSS_BOOT
  } fss_state_t;

  // State codes as seen by software and the master
  localparam logic [2:0] ST_INIT = 3'h1;
  localparam logic [2:0] ST_PREOP = 3'h2;
  localparam logic [2:0] ST_BOOT = 3'h3;
  localparam logic [2:0] ST_SAFE_OPERATIONAL_MODE = 3'h4;
  localparam logic [2:0] ST_OP = 3'h0;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CFG = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
  localparam logic [7:0] REG_IRQ_EN = 8'h10;
  localparam logic [7:0] REG_IRQ_CLR = 8'h14;
  localparam logic [7:0] REG_TIME_LO = 8'h18;
  localparam logic [7:0] REG_TIME_HI = 8'h1C;
  localparam logic [7:0] REG_TIME_ADJ = 8'h20;
  localparam logic [7:0] REG_OUT_DATA = 8'h24;
  localparam logic [7:0] REG_IN_IMAGE = 8'h28;

  // Control fields
  localparam int CTRL_REQ_LSB = 0;
  localparam int CTRL_REQ_STB = 3;
  localparam int CTRL_WD_DIS = 4;
  localparam int CTRL_SHORT_TIME = 5;

  // Configuration valid bits and the clock-use flag
  localparam int CFG_MBX_OK = 0;
  localparam int CFG_PD_OK = 1;
  localparam int CFG_DC_OK = 2;
  localparam int CFG_DC_USED = 3;

  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERR = 1;
  localparam int IRQ_W = 2;

  // Timing: one clock period is 25 ns
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [63:0] TIME_STEP = 64'(CLK_PERIOD_NS);
  localparam int SYNC_ERR_MAX_NS = 100;
endpackage

// File: design/fss_slave.sv
`timescale 1ns/10ps
// Function
// - Reset into init; refuse mailbox and process data there.
// - Init to preoperational only if mailbox setup checks valid.
// - Preoperational allows mailbox, blocks process data.
// - Preop to safe_operational_state checks process-data setup and clock setup if used.
// - Capture inputs into memory image before acknowledging safe_operational_state entry.
// - Safe_operational_state allows mailbox and process data, refreshes inputs, holds outputs safe.
// - Watchdog forces safe outputs unless disabled, then safe_operational_state may drive.
// - Operational applies master outputs to physical outputs.
// - Boot reachable only from init; other boot requests rejected.
// - Boot allows only file-transfer mailbox; no process data.
// - Local time counts nanoseconds, 64 bits, zero at year 2000 start.
// - Reduced mode keeps only a 32-bit wrapping time.
// - Apply master time corrections to keep error below 100 ns.
// - No object dictionary service; such requests are never answered.
module fss_slave #(
  parameter int IO_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Physical I/O pins
  input wire logic [IO_W-1:0] phys_in,
  output logic [IO_W-1:0] phys_out,
  // Traffic gates toward the frame logic, and the interrupt line
  output logic mbx_enable,
  output logic file_mbx_only,
  output logic pd_enable,
  output logic odict_enable,
  output logic irq
);
  if (IO_W < 1 || IO_W > 32) begin : g_io_w_chk // Readback is one word
    $error("IO_W must be 1..32");
  end
  fss_pkg::fss_state_t st_reg, st_next;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [3:0] cfg_reg, cfg_next;
  logic [fss_pkg::IRQ_W-1:0] ist_reg, ist_next, ien_reg, ien_next;
  logic [63:0] time_reg, time_next;
  logic [IO_W-1:0] out_reg, out_next, img_reg, img_next;
  logic [IO_W-1:0] drv_reg, drv_next;
  logic [IO_W-1:0] in_s1_reg, in_s2_reg;
  logic err_reg, err_next;
  logic aw_reg, aw_next, w_reg, w_next, b_reg, b_next, r_reg, r_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next, rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  // Merge byte lanes of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Visible code of a state
  function automatic logic [2:0] code(input fss_pkg::fss_state_t s);
    case (s)
      fss_pkg::FSS_INIT: code = fss_pkg::ST_INIT;
      fss_pkg::FSS_PREOP: code = fss_pkg::ST_PREOP;
      fss_pkg::FSS_SAFE_OPERATIONAL_MODE: code = fss_pkg::ST_SAFE_OPERATIONAL_MODE;
      fss_pkg::FSS_OP: code = fss_pkg::ST_OP;
      fss_pkg::FSS_BOOT: code = fss_pkg::ST_BOOT;
      default: code = fss_pkg::ST_INIT;
    endcase
  endfunction

  // Pin inputs cross into the clock domain first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
    end else begin
      in_s1_reg <= phys_in;
      in_s2_reg <= in_s1_reg;
    end
  end
  logic wr_fire, rd_fire, req_stb, dc_need;
  logic [2:0] req;
  logic [31:0] wmerged;
  assign wr_fire = aw_reg && w_reg && !b_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign wmerged = merge(32'h00000000, wd_reg, 4'hF);
  assign req_stb = wr_fire && awa_reg == fss_pkg::REG_CTRL
                   && wd_reg[fss_pkg::CTRL_REQ_STB];
  assign req = wd_reg[fss_pkg::CTRL_REQ_LSB +: 3];
  assign dc_need = cfg_reg[fss_pkg::CFG_DC_USED];
  // Bus, state machine, time and I/O next values
  always_comb begin
    aw_next = aw_reg;
    w_next = w_reg;
    b_next = b_reg;
    r_next = r_reg;
    awa_next = awa_reg;
    wd_next = wd_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    st_next = st_reg;
    ctrl_next = ctrl_reg;
    cfg_next = cfg_reg;
    ien_next = ien_reg;
    ist_next = ist_reg;
    err_next = err_reg;
    out_next = out_reg;
    img_next = img_reg;
    drv_next = drv_reg;
    time_next = time_reg + fss_pkg::TIME_STEP;
    // Write channels taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_next = 1'b1;
      awa_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_next = 1'b1;
      wd_next = merge(32'h00000000, s_axi_wdata, s_axi_wstrb);
    end
    if (s_axi_bvalid && s_axi_bready) begin
      b_next = 1'b0;
    end
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      b_next = 1'b1;
      case (awa_reg)
        fss_pkg::REG_CTRL: begin
          ctrl_next = wmerged;
          ctrl_next[fss_pkg::CTRL_REQ_STB] = 1'b0;
        end
        fss_pkg::REG_CFG: cfg_next = wmerged[3:0];
        fss_pkg::REG_IRQ_EN: ien_next = wmerged[fss_pkg::IRQ_W-1:0];
        fss_pkg::REG_IRQ_CLR: ist_next = ist_reg
                                & ~wmerged[fss_pkg::IRQ_W-1:0];
        // Corrections land on the next tick; step drift stays one period
        fss_pkg::REG_TIME_LO: time_next[31:0] = wmerged;
        fss_pkg::REG_TIME_HI: time_next[63:32] = wmerged;
        fss_pkg::REG_TIME_ADJ: time_next = time_reg
                               + {{32{wmerged[31]}}, wmerged};
        fss_pkg::REG_OUT_DATA: out_next = wmerged[IO_W-1:0];
        default: ;
      endcase
    end
    if (ctrl_reg[fss_pkg::CTRL_SHORT_TIME]) begin // Last, so writes obey it
      time_next[63:32] = 32'h00000000;
    end
    // State requests; a refused one keeps the state
    if (req_stb) begin
      err_next = 1'b1;
      case (st_reg)
        fss_pkg::FSS_INIT: begin
          if (req == fss_pkg::ST_INIT) begin
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_PREOP
                       && cfg_reg[fss_pkg::CFG_MBX_OK]) begin
            st_next = fss_pkg::FSS_PREOP;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_BOOT
                       && cfg_reg[fss_pkg::CFG_MBX_OK]) begin
            st_next = fss_pkg::FSS_BOOT;
            err_next = 1'b0;
          end
        end
        fss_pkg::FSS_PREOP: begin
          if (req == fss_pkg::ST_INIT) begin
            st_next = fss_pkg::FSS_INIT;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_PREOP) begin
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_SAFE_OPERATIONAL_MODE
                       && cfg_reg[fss_pkg::CFG_PD_OK]
                       && (!dc_need || cfg_reg[fss_pkg::CFG_DC_OK])) begin
            st_next = fss_pkg::FSS_SAFE_OPERATIONAL_MODE;
            img_next = in_s2_reg;
            err_next = 1'b0;
          end
        end
        fss_pkg::FSS_SAFE_OPERATIONAL_MODE, fss_pkg::FSS_OP: begin
          if (req == fss_pkg::ST_INIT) begin
            st_next = fss_pkg::FSS_INIT;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_PREOP) begin
            st_next = fss_pkg::FSS_PREOP;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_SAFE_OPERATIONAL_MODE) begin
            st_next = fss_pkg::FSS_SAFE_OPERATIONAL_MODE;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_OP) begin
            st_next = fss_pkg::FSS_OP;
            err_next = 1'b0;
          end
        end
        fss_pkg::FSS_BOOT: begin
          if (req == fss_pkg::ST_INIT) begin
            st_next = fss_pkg::FSS_INIT;
            err_next = 1'b0;
          end else if (req == fss_pkg::ST_BOOT) begin
            err_next = 1'b0;
          end
        end
        default: st_next = fss_pkg::FSS_INIT;
      endcase
    end
    // Input image refreshes every cycle in the data-exchanging states
    if (st_reg == fss_pkg::FSS_SAFE_OPERATIONAL_MODE || st_reg == fss_pkg::FSS_OP) begin
      img_next = in_s2_reg;
    end
    // Pins follow master data in op, or in safe_operational_state without watchdog
    if (st_reg == fss_pkg::FSS_OP) begin
      drv_next = out_reg;
    end else if (st_reg == fss_pkg::FSS_SAFE_OPERATIONAL_MODE
                 && ctrl_reg[fss_pkg::CTRL_WD_DIS]) begin
      drv_next = out_reg;
    end else begin
      drv_next = '0;
    end
    // Sticky events; a set outranks a clear in the same cycle
    if (req_stb) begin
      ist_next[fss_pkg::IRQ_DONE] = 1'b1;
    end
    if (err_next && !err_reg) begin
      ist_next[fss_pkg::IRQ_ERR] = 1'b1;
    end
    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      r_next = 1'b0;
    end
    if (rd_fire) begin
      r_next = 1'b1;
      rr_next = 2'h0;
      case (s_axi_araddr)
        fss_pkg::REG_CTRL: rd_next = ctrl_reg;
        fss_pkg::REG_STATUS: rd_next = {27'h0000000, err_reg,
                                        1'b0, code(st_reg)};
        fss_pkg::REG_CFG: rd_next = {28'h0000000, cfg_reg};
        fss_pkg::REG_IRQ_STAT: rd_next = 32'(ist_reg);
        fss_pkg::REG_IRQ_EN: rd_next = 32'(ien_reg);
        fss_pkg::REG_TIME_LO: rd_next = time_reg[31:0];
        fss_pkg::REG_TIME_HI: rd_next = time_reg[63:32];
        fss_pkg::REG_OUT_DATA: rd_next = 32'(out_reg);
        fss_pkg::REG_IN_IMAGE: rd_next = 32'(img_reg);
        default: begin
          rd_next = 32'h00000000;
          rr_next = 2'h2;
        end
      endcase
    end
  end

  // All registers except the pin synchronizer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= fss_pkg::FSS_INIT;
      ctrl_reg <= 32'h00000000;
      cfg_reg <= 4'h0;
      ist_reg <= '0;
      ien_reg <= '0;
      err_reg <= 1'b0;
      time_reg <= 64'h0000000000000000;
      out_reg <= '0;
      img_reg <= '0;
      drv_reg <= '0;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      b_reg <= 1'b0;
      r_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h00000000;
      rd_reg <= 32'h00000000;
      rr_reg <= 2'h0;
    end else begin
      st_reg <= st_next;
      ctrl_reg <= ctrl_next;
      cfg_reg <= cfg_next;
      ist_reg <= ist_next;
      ien_reg <= ien_next;
      err_reg <= err_next;
      time_reg <= time_next;
      out_reg <= out_next;
      img_reg <= img_next;
      drv_reg <= drv_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      b_reg <= b_next;
      r_reg <= r_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  // Handshakes; one write and one read at a time
  assign s_axi_awready = !aw_reg && !b_reg;
  assign s_axi_wready = !w_reg && !b_reg;
  assign s_axi_bvalid = b_reg;
  assign s_axi_bresp = 2'h0;
  assign s_axi_arready = !r_reg;
  assign s_axi_rvalid = r_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign phys_out = drv_reg;
  assign irq = |(ist_reg & ien_reg);
  // Traffic gates per state
  assign mbx_enable = st_reg != fss_pkg::FSS_INIT;
  assign file_mbx_only = st_reg == fss_pkg::FSS_BOOT;
  assign pd_enable = st_reg == fss_pkg::FSS_SAFE_OPERATIONAL_MODE
                     || st_reg == fss_pkg::FSS_OP;
  assign odict_enable = 1'b0;
endmodule

// File: bench/fss_io_model.sv
`timescale 1ns/10ps
// Pin-side source feeding the input pins of the slave
module fss_io_model (
  // Clock
  input wire logic aclk,
  // Commanded pin pattern and pins
  input wire logic [7:0] pat,
  output logic [7:0] phys_in
);
  // Pins move just after an edge, never mid-cycle
  always_ff @(posedge aclk) begin
    phys_in <= pat;
  end
endmodule

// File: bench/fss_slave_checker.sv
`timescale 1ns/10ps
module fss_slave_checker #(
  parameter int IO_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus answers
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_arready,
  // Pins and gates
  input wire logic [IO_W-1:0] phys_out,
  input wire logic mbx_enable,
  input wire logic file_mbx_only,
  input wire logic pd_enable,
  input wire logic odict_enable
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  odict_off_a: assert property (!odict_enable)
    else $error("dictionary gate raised");
  init_quiet_a: assert property (
    $rose(aresetn) |-> !mbx_enable && !pd_enable)
    else $error("traffic open after reset");
  pd_gate_a: assert property (
    pd_enable |-> mbx_enable && !file_mbx_only)
    else $error("process data outside run states");
  // Outputs lag the state by one cycle, hence the past term
  safe_out_a: assert property (
    !pd_enable && !$past(pd_enable) |-> phys_out == '0)
    else $error("outputs driven while stopped");
  boot_entry_a: assert property (
    $rose(file_mbx_only) |-> !$past(mbx_enable))
    else $error("boot entered from non-init");
  pd_entry_a: assert property (
    $rose(pd_enable) |-> $past(mbx_enable) && !$past(file_mbx_only))
    else $error("run state entered from wrong state");
  bresp_ok_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
    else $error("write response not okay");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule
bind fss_slave fss_slave_checker #(.IO_W(IO_W)) chk_i (.aclk(aclk),
  .aresetn(aresetn), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_arready(s_axi_arready),
  .phys_out(phys_out), .mbx_enable(mbx_enable),
  .file_mbx_only(file_mbx_only), .pd_enable(pd_enable),
  .odict_enable(odict_enable));

// File: bench/tb_fss_slave.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin error_cnt++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module tb_fss_slave;
  // Bench signals
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, pat = 8'h00, phys_in, phys_out;
  logic [31:0] wdata = 0, rdata, rd_data, t0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rd_resp;
  logic mbx_enable, file_mbx_only, pd_enable, odict_enable, irq;
  int error_cnt = 0, compares = 0;
  fss_slave #(.IO_W(8)) fss_slave_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .phys_in(phys_in),
    .phys_out(phys_out), .mbx_enable(mbx_enable),
    .file_mbx_only(file_mbx_only), .pd_enable(pd_enable),
    .odict_enable(odict_enable), .irq(irq));
  fss_io_model fss_io_model_i (.aclk(aclk), .pat(pat), .phys_in(phys_in));
  // Clock
  initial forever #12.5 aclk = ~aclk;
  task test_done;
    $display("Counts: errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One bus cycle; handshakes sampled at the edge, released after it
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    if (w) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    while (!done) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
      end
      if (rready && rvalid) begin
        rready <= 1'b0;
        rd_data = rdata;
        rd_resp = rresp;
        done = 1'b1;
      end
      if (n == 50) begin
        error_cnt++;
        $display("ERROR bus answer exp 1 got 0");
        test_done;
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h00000000);
  endtask
  // Registered outputs lag the state by a cycle
  task settle;
    repeat (4) @(posedge aclk);
  endtask
  task automatic st(input logic [2:0] c);
    rd(fss_pkg::REG_STATUS);
    `CHK("state", c, rd_data[2:0])
  endtask
  task t_reset;
    st(fss_pkg::ST_INIT);
    `CHK("mbx", 1'b0, mbx_enable)
    `CHK("pd", 1'b0, pd_enable)
    rd(8'h3C);
    `CHK("rresp", 2'h2, rd_resp)
    $display("test reset done");
  endtask
  task t_fail;
    wr(fss_pkg::REG_CFG, 32'h0);
    wr(fss_pkg::REG_IRQ_EN, 32'h0);
    wr(fss_pkg::REG_CTRL, 32'hA);
    st(fss_pkg::ST_INIT);
    `CHK("err", 1'b1, rd_data[4])
    rd(fss_pkg::REG_IRQ_STAT);
    `CHK("istat", 2'h3, rd_data[1:0])
    `CHK("irq off", 1'b0, irq)
    wr(fss_pkg::REG_IRQ_EN, 32'h2);
    settle;
    `CHK("irq on", 1'b1, irq)
    wr(fss_pkg::REG_IRQ_CLR, 32'h3);
    settle;
    `CHK("irq clr", 1'b0, irq)
    $display("test fail done");
  endtask
  task t_boot;
    wr(fss_pkg::REG_CFG, 32'h1);
    wr(fss_pkg::REG_CTRL, 32'hB);
    st(fss_pkg::ST_BOOT);
    `CHK("fonly", 1'b1, file_mbx_only)
    `CHK("pd boot", 1'b0, pd_enable)
    `CHK("odict", 1'b0, odict_enable)
    wr(fss_pkg::REG_CTRL, 32'h9);
    st(fss_pkg::ST_INIT);
    wr(fss_pkg::REG_CTRL, 32'hA);
    st(fss_pkg::ST_PREOP);
    `CHK("mbx pre", 1'b1, mbx_enable)
    `CHK("pd pre", 1'b0, pd_enable)
    wr(fss_pkg::REG_CTRL, 32'hB);
    st(fss_pkg::ST_PREOP);
    $display("test boot done");
  endtask
  task t_run;
    @(posedge aclk);
    pat <= 8'h5A;
    wr(fss_pkg::REG_CTRL, 32'hC);
    st(fss_pkg::ST_PREOP);
    wr(fss_pkg::REG_CFG, 32'hB);
    wr(fss_pkg::REG_CTRL, 32'hC);
    st(fss_pkg::ST_PREOP);
    wr(fss_pkg::REG_CFG, 32'hF);
    wr(fss_pkg::REG_CTRL, 32'hC);
    st(fss_pkg::ST_SAFE_OPERATIONAL_MODE);
    rd(fss_pkg::REG_IN_IMAGE);
    `CHK("image", 8'h5A, rd_data[7:0])
    `CHK("pd safe", 1'b1, pd_enable)
    wr(fss_pkg::REG_OUT_DATA, 32'hC3);
    pat <= 8'hA5;
    settle;
    `CHK("out safe", 8'h00, phys_out)
    rd(fss_pkg::REG_IN_IMAGE);
    `CHK("refresh", 8'hA5, rd_data[7:0])
    wr(fss_pkg::REG_CTRL, 32'h1C);
    settle;
    `CHK("out wd off", 8'hC3, phys_out)
    wr(fss_pkg::REG_CTRL, 32'h8);
    st(fss_pkg::ST_OP);
    settle;
    `CHK("out op", 8'hC3, phys_out)
    wr(fss_pkg::REG_CTRL, 32'h9);
    settle;
    `CHK("out init", 8'h00, phys_out)
    $display("test run done");
  endtask
  task t_time;
    rd(fss_pkg::REG_TIME_LO);
    t0 = rd_data;
    rd(fss_pkg::REG_TIME_LO);
    `CHK("tick", 32'h0, (rd_data - t0) % 25)
    `CHK("moving", 1'b1, rd_data != t0)
    t0 = rd_data;
    wr(fss_pkg::REG_TIME_ADJ, 32'h7);
    rd(fss_pkg::REG_TIME_LO);
    `CHK("adjust", 32'h7, (rd_data - t0) % 25)
    wr(fss_pkg::REG_CTRL, 32'h20);
    wr(fss_pkg::REG_TIME_HI, 32'h5);
    rd(fss_pkg::REG_TIME_HI);
    `CHK("short hi", 32'h0, rd_data)
    $display("test time done");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_fail;
    t_boot;
    t_run;
    t_time;
    test_done;
  end
endmodule
